// ==== logic/tg_cfg.svh ====
// Register indices, field positions, reset values and counts of the tone generator
`ifndef TG_CFG_SVH
`define TG_CFG_SVH
// Register indices; the byte address is four times the index
`define TG_IDX_HIGH_GROUP_FREQ 6'h11
`define TG_IDX_LOW_GROUP_FREQ 6'h12
`define TG_IDX_CLOCK_MELODY_CONTROL 6'h13
`define TG_IDX_STATUS 6'h14
// Control register fields
`define TG_BIT_MELODY_ENABLE 0
`define TG_BIT_DIVIDE_BY_THREE 1
`define TG_BIT_CLOCK_OUT_ENABLE 2
`define TG_CTRL_W 3
// Status register fields
`define TG_ST_GEN_ACTIVE 0
`define TG_ST_MELODY_WAVE 1
`define TG_ST_TONE_DRIVE 2
`define TG_ST_HIGH_RUN 3
`define TG_ST_LOW_RUN 4
`define TG_ST_W 5
// Reset values
`define TG_FREQ_RESET 8'h00
`define TG_CTRL_RESET 3'h0
`define TG_RDATA_ZERO 32'h0000_0000
// Crystal phase counter: sys_clk runs at twice the crystal rate
`define TG_DIV1_LAST 3'h1
`define TG_DIVIDE_BY_THREE_SELECT_LAST 3'h5
`define TG_DIVIDE_BY_THREE_SELECT_HIGH 3'h3
`define TG_DIV1_HIGH 3'h1
// Synthesizer: 23 phase steps per period, high for the first 12
`define TG_PHASE_LAST 5'h16
`define TG_PHASE_DUTY 5'h0C
`define TG_FREQ_OFF 8'h00
`define TG_MELODY_MIN 8'h02
`define TG_TONE_MIN 8'h3C
`endif

// ==== logic/tg_pkg.sv ====
// Types shared by the tone generator control logic
package tg_pkg;
  // Clock and melody control fields
  typedef struct packed {
    logic clock_out_enable;
    logic divide_by_three_select;
    logic melody_enable;
  } tg_ctrl_t;
  // Drive of one quasi-bidirectional line
  typedef struct packed {
    logic out;
    logic oe;
  } tg_line_t;
  // State of one synthesizer
  typedef struct packed {
    logic [8:0] pre;
    logic [4:0] phase;
  } tg_synth_t;
endpackage : tg_pkg

// ==== logic/tg_top.sv ====
// Tone generator: frequency and control registers, tone clock divider, shared clock and melody lines
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ps
`include "tg_cfg.svh"
// Operation
// R1: tone clock is crystal, or crystal over three
// R2: clock-out disabled: line is plain port
// R3: clock-out enabled: line carries tone clock square
// R4: clock line port latch stays readable, writable
// R5: software keeps clock line latch high
// R6: melody disabled: line is plain port
// R7: melody enabled: line carries melody square wave
// R8: melody line port latch stays readable, writable
// R9: software keeps melody line latch high
// R10: melody enabled, high freq zero: line high
// R11: control register upper five bits read zero
// R12: write-only high and low frequency registers
// R13: control register holds clock-out, divider, melody
// R14: no frequency selected: tone pin high-impedance
// R15: two octaves semitones: tone sine, melody square
// R16: zero stops synthesizer; both zero shuts down
// R17: frequency is clock over 23 times (x+2)
// R18: melody usable down to value two
// R19: reset clears control and frequency registers
module tg_top #(
  parameter int ADDR_W = 8
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic clk_line_latch_wr,
  input wire logic clk_line_latch_wdata,
  input wire logic clk_line_in,
  output logic clk_line_out,
  output logic clk_line_oe,
  output logic clk_line_latch,
  output logic clk_line_pin_state,
  input wire logic mel_line_latch_wr,
  input wire logic mel_line_latch_wdata,
  input wire logic mel_line_in,
  output logic mel_line_out,
  output logic mel_line_oe,
  output logic mel_line_latch,
  output logic mel_line_pin_state,
  output logic tone_oe,
  output logic [4:0] tone_high_phase,
  output logic [4:0] tone_low_phase,
  output logic tone_power_down
);

  // Quasi-bidirectional drive: a port latch of 0 pulls low; a 1 lets the alternate wave through
  function automatic tg_pkg::tg_line_t line_drive(input logic alt_en, input logic wave, input logic latch);
    tg_pkg::tg_line_t d;
    d.out = 1'b0;
    d.oe = 1'b0;
    if (!latch) begin
      d.oe = 1'b1;
    end else if (alt_en) begin
      d.out = wave;
      d.oe = 1'b1;
    end
    return d;
  endfunction : line_drive

  // One tone-clock step of a synthesizer: (x+2) ticks per phase, 23 phases per period
  function automatic tg_pkg::tg_synth_t synth_step(input tg_pkg::tg_synth_t s, input logic [7:0] x,
                                                 input logic tick);
    tg_pkg::tg_synth_t n;
    logic [8:0] pre_last;
    n = s;
    pre_last = {1'b0, x} + 9'h001;
    if (x == `TG_FREQ_OFF) begin
      n = '0;
    end else if (tick) begin
      if (s.pre >= pre_last) begin
        n.pre = 9'h000;
        n.phase = (s.phase >= `TG_PHASE_LAST) ? 5'h00 : s.phase + 5'h01;
      end else begin
        n.pre = s.pre + 9'h001;
      end
    end
    return n;
  endfunction : synth_step

  logic [7:0] high_group_freq;
  logic [7:0] low_group_freq;
  tg_pkg::tg_ctrl_t ctrl;
  logic [ADDR_W-3:0] idx;
  logic bus_req;
  logic bus_done;
  logic [2:0] dcnt;
  logic [2:0] dcnt_last;
  logic tone_tick;
  logic clk_wave;
  tg_pkg::tg_synth_t high_synth;
  tg_pkg::tg_synth_t low_synth;
  logic high_run;
  logic low_run;
  logic melody_wave;
  logic gen_active;
  logic [1:0] pin_s1;
  logic [1:0] pin_s2;
  logic [1:0] pin_s3;
  tg_pkg::tg_line_t next_clk_line;
  tg_pkg::tg_line_t next_mel_line;
  logic [31:0] next_rdata;

  assign idx = avs_address[ADDR_W-1:2];
  assign bus_req = avs_read || avs_write;
  assign bus_done = bus_req && !avs_waitrequest;

  // Bus handshake: waitrequest drops for one cycle, one cycle after a request is seen
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else if (ce) begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
    end
  end

  // Read mux: write-only and unmapped words read zero
  always_comb begin
    next_rdata = `TG_RDATA_ZERO;
    if (idx == `TG_IDX_CLOCK_MELODY_CONTROL) begin
      next_rdata[`TG_CTRL_W-1:0] = ctrl; // R11 R13
    end else if (idx == `TG_IDX_STATUS) begin
      next_rdata[`TG_ST_GEN_ACTIVE] = gen_active;
      next_rdata[`TG_ST_MELODY_WAVE] = melody_wave;
      next_rdata[`TG_ST_TONE_DRIVE] = tone_oe;
      next_rdata[`TG_ST_HIGH_RUN] = high_run;
      next_rdata[`TG_ST_LOW_RUN] = low_run;
    end
  end

  // Read data captured while waitrequest is still high, so it stands on the accepting edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= `TG_RDATA_ZERO;
    end else if (ce && avs_read && avs_waitrequest) begin
      avs_readdata <= next_rdata;
    end
  end

  // Frequency registers, written on the accepting edge with byte lane 0
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      high_group_freq <= `TG_FREQ_RESET; // R19
      low_group_freq <= `TG_FREQ_RESET; // R19
    end else if (ce && avs_write && bus_done && avs_byteenable[0]) begin
      if (idx == `TG_IDX_HIGH_GROUP_FREQ) begin
        high_group_freq <= avs_writedata[7:0]; // R12
      end
      if (idx == `TG_IDX_LOW_GROUP_FREQ) begin
        low_group_freq <= avs_writedata[7:0]; // R12
      end
    end
  end

  // Control register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `TG_CTRL_RESET; // R19
    end else if (ce && avs_write && bus_done && avs_byteenable[0] && idx == `TG_IDX_CLOCK_MELODY_CONTROL) begin
      ctrl.clock_out_enable <= avs_writedata[`TG_BIT_CLOCK_OUT_ENABLE]; // R13
      ctrl.divide_by_three_select <= avs_writedata[`TG_BIT_DIVIDE_BY_THREE]; // R13
      ctrl.melody_enable <= avs_writedata[`TG_BIT_MELODY_ENABLE]; // R13
    end
  end

  // Crystal phase counter: two steps per crystal period, six per divided period
  assign dcnt_last = ctrl.divide_by_three_select ? `TG_DIVIDE_BY_THREE_SELECT_LAST : `TG_DIV1_LAST; // R1
  assign tone_tick = (dcnt >= dcnt_last);
  assign clk_wave = ctrl.divide_by_three_select ? (dcnt < `TG_DIVIDE_BY_THREE_SELECT_HIGH) : (dcnt < `TG_DIV1_HIGH); // R1 R3

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dcnt <= 3'h0;
    end else if (ce) begin
      dcnt <= tone_tick ? 3'h0 : dcnt + 3'h1; // R1
    end
  end

  // Synthesizers stepped by the tone clock; zero holds one stopped
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      high_synth <= '0;
      low_synth <= '0;
    end else if (ce) begin
      high_synth <= synth_step(high_synth, high_group_freq, tone_tick); // R16 R17 R18
      low_synth <= synth_step(low_synth, low_group_freq, tone_tick); // R16 R17
    end
  end

  assign high_run = (high_group_freq != `TG_FREQ_OFF); // R16
  assign low_run = (low_group_freq != `TG_FREQ_OFF); // R16
  assign gen_active = high_run || low_run; // R16
  // Melody is high for 12 of 23 phases, and static high while stopped
  assign melody_wave = !high_run || (high_synth.phase < `TG_PHASE_DUTY); // R10 R15 R18

  // Tone pin: phase words for the converters, high impedance when nothing runs
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tone_oe <= 1'b0;
      tone_high_phase <= 5'h00;
      tone_low_phase <= 5'h00;
      tone_power_down <= 1'b1;
    end else if (ce) begin
      tone_oe <= gen_active; // R14
      tone_high_phase <= high_synth.phase; // R15 R17
      tone_low_phase <= low_synth.phase; // R17
      tone_power_down <= !gen_active; // R16
    end
  end

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1 <= 2'h3;
      pin_s2 <= 2'h3;
      pin_s3 <= 2'h3;
      clk_line_pin_state <= 1'b1;
      mel_line_pin_state <= 1'b1;
    end else if (ce) begin
      pin_s1 <= {mel_line_in, clk_line_in};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2[0] == pin_s3[0]) begin
        clk_line_pin_state <= pin_s3[0]; // R4
      end
      if (pin_s2[1] == pin_s3[1]) begin
        mel_line_pin_state <= pin_s3[1]; // R8
      end
    end
  end

  // Port latches stay writable by port instructions whatever the alternate function
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_line_latch <= 1'b1;
      mel_line_latch <= 1'b1;
    end else if (ce) begin
      if (clk_line_latch_wr) begin
        clk_line_latch <= clk_line_latch_wdata; // R4
      end
      if (mel_line_latch_wr) begin
        mel_line_latch <= mel_line_latch_wdata; // R8
      end
    end
  end

  // Line drive; a low latch pulls the pin low, so keeping it high avoids contention
  assign next_clk_line = line_drive(ctrl.clock_out_enable, clk_wave, clk_line_latch); // R2 R3 R5
  assign next_mel_line = line_drive(ctrl.melody_enable, melody_wave, mel_line_latch); // R6 R7 R9

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clk_line_out <= 1'b0;
      clk_line_oe <= 1'b0;
      mel_line_out <= 1'b0;
      mel_line_oe <= 1'b0;
    end else if (ce) begin
      clk_line_out <= next_clk_line.out; // R2 R3
      clk_line_oe <= next_clk_line.oe; // R2 R3
      mel_line_out <= next_mel_line.out; // R6 R7
      mel_line_oe <= next_mel_line.oe; // R6 R7
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_write_high;
    ce && avs_write && bus_done && avs_byteenable[0] && idx == `TG_IDX_HIGH_GROUP_FREQ;
  endsequence
  sequence s_read_ctrl;
    ce && avs_read && avs_waitrequest && idx == `TG_IDX_CLOCK_MELODY_CONTROL;
  endsequence
  sequence s_clk_pin_agree;
    ce && pin_s2[0] == pin_s3[0];
  endsequence
  sequence s_mel_pin_agree;
    ce && pin_s2[1] == pin_s3[1];
  endsequence

  a_wait_one_cycle: assert property (ce && bus_req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest did not drop for exactly one cycle");
  a_freq_write: assert property (s_write_high |=> high_group_freq == $past(avs_writedata[7:0])) // R12
    else $error("high group frequency write lost");
  a_ctrl_upper_zero: assert property (s_read_ctrl |=> avs_readdata[7:3] == 5'h00 && avs_readdata[2:0] == $past(ctrl)) // R11
    else $error("control readback wrong");
  a_div_three_period: assert property (ce && ctrl.divide_by_three_select // R1
    |=> dcnt == (($past(dcnt) == `TG_DIVIDE_BY_THREE_SELECT_LAST) ? 3'h0 : $past(dcnt) + 3'h1))
    else $error("divide by three period wrong");
  a_div_one_wrap: assert property (ce && !ctrl.divide_by_three_select && dcnt == 3'h1 |=> dcnt == 3'h0) // R1
    else $error("undivided tone clock wrong");
  a_clk_line_plain: assert property (ce && !ctrl.clock_out_enable // R2
    |=> clk_line_oe == !$past(clk_line_latch) && !clk_line_out)
    else $error("clock line not a plain port");
  a_clk_line_wave: assert property (ce && ctrl.clock_out_enable && clk_line_latch // R3
    |=> clk_line_oe && clk_line_out == $past(clk_wave))
    else $error("clock line wave missing");
  a_latch_write: assert property (ce && mel_line_latch_wr |=> mel_line_latch == $past(mel_line_latch_wdata)) // R8
    else $error("melody latch write lost");
  a_mel_static_high: assert property (ce && ctrl.melody_enable && mel_line_latch && !high_run // R10
    |=> mel_line_oe && mel_line_out)
    else $error("melody line not static high");
  a_mel_plain: assert property (ce && !ctrl.melody_enable |=> mel_line_oe == !$past(mel_line_latch)) // R6
    else $error("melody line not a plain port");
  a_tone_hiz: assert property (ce && !gen_active |=> !tone_oe && tone_power_down) // R14
    else $error("tone pin driven while generator off");
  a_phase_wrap: assert property (ce && tone_tick && high_run && high_synth.phase == `TG_PHASE_LAST // R17
    && high_synth.pre >= {1'b0, high_group_freq} + 9'h001 && $stable(high_group_freq)
    |=> high_synth.phase == 5'h00)
    else $error("melody period not 23 phases");
  // Alternate drive, port latch, synchroniser, lane and generator power checks
  a_mel_wave: assert property (ce && ctrl.melody_enable && mel_line_latch // R7
    |=> mel_line_oe && mel_line_out == $past(melody_wave))
    else $error("melody line wave missing");
  a_clk_latch_write: assert property (ce && clk_line_latch_wr // R4
    |=> clk_line_latch == $past(clk_line_latch_wdata))
    else $error("clock line latch write lost");
  a_clk_pin_sync: assert property (s_clk_pin_agree |=> clk_line_pin_state == $past(pin_s3[0])) // R4
    else $error("clock line pin state not updated");
  a_mel_pin_sync: assert property (s_mel_pin_agree |=> mel_line_pin_state == $past(pin_s3[1])) // R8
    else $error("melody line pin state not updated");
  a_tone_drive: assert property (ce && gen_active |=> tone_oe && !tone_power_down) // R14 R16
    else $error("tone pin not driven while generator runs");
  a_synth_stop: assert property (ce && !high_run |=> high_synth.pre == 9'h000 && high_synth.phase == 5'h00) // R16
    else $error("high synthesizer not stopped");
  a_low_synth_stop: assert property (ce && !low_run |=> low_synth.pre == 9'h000 && low_synth.phase == 5'h00) // R16
    else $error("low synthesizer not stopped");
  a_lane_ignored: assert property (ce && avs_write && bus_done && !avs_byteenable[0] // R12 R13
    |=> $stable(ctrl) && $stable(high_group_freq) && $stable(low_group_freq))
    else $error("write without lane 0 changed a register");
  a_phase_range: assert property (high_synth.phase <= `TG_PHASE_LAST && low_synth.phase <= `TG_PHASE_LAST) // R17
    else $error("synthesizer phase beyond 23 steps");

endmodule : tg_top

// ==== testbench/tg_line_model.sv ====
// External circuit on one quasi-bidirectional line: pull-up plus resolved pin level
`timescale 1ns/1ps
module tg_line_model (
  input wire logic out,
  input wire logic oe,
  output logic level
);
  // Released line floats to the pull-up level
  assign level = oe ? out : 1'b1;
endmodule : tg_line_model

// ==== testbench/tb_tone_generator_clock_and_melody_control.sv ====
// Self-checking bench for the tone generator registers, clock line and melody line
`timescale 1ns/1ps
`include "tg_cfg.svh"
module tb_tone_generator_clock_and_melody_control;
  logic sys_clk, resetn, ce, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic clk_wr, clk_wd, clk_in, clk_out, clk_oe, clk_latch, clk_pin;
  logic mel_wr, mel_wd, mel_in, mel_out, mel_oe, mel_latch, mel_pin;
  logic tone_oe, tone_power_down;
  logic [4:0] hi_ph, lo_ph;
  int err_total, n_tests, cyc, hs, tg;
  localparam logic [7:0] A_HGF = {`TG_IDX_HIGH_GROUP_FREQ, 2'b00};
  localparam logic [7:0] A_LGF = {`TG_IDX_LOW_GROUP_FREQ, 2'b00};
  localparam logic [7:0] A_CTL = {`TG_IDX_CLOCK_MELODY_CONTROL, 2'b00};
  localparam logic [7:0] A_STS = {`TG_IDX_STATUS, 2'b00};
  tg_top u_tg_top (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clk_line_latch_wr(clk_wr), .clk_line_latch_wdata(clk_wd), .clk_line_in(clk_in),
    .clk_line_out(clk_out), .clk_line_oe(clk_oe), .clk_line_latch(clk_latch), .clk_line_pin_state(clk_pin),
    .mel_line_latch_wr(mel_wr), .mel_line_latch_wdata(mel_wd), .mel_line_in(mel_in),
    .mel_line_out(mel_out), .mel_line_oe(mel_oe), .mel_line_latch(mel_latch), .mel_line_pin_state(mel_pin),
    .tone_oe(tone_oe), .tone_high_phase(hi_ph), .tone_low_phase(lo_ph), .tone_power_down(tone_power_down));
  tg_line_model u_clk_line (.out(clk_out), .oe(clk_oe), .level(clk_in));
  tg_line_model u_mel_line (.out(mel_out), .oe(mel_oe), .level(mel_in));
  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle
  task bus_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 40);
    avs_write <= 1'b0;
    if (n >= 40) err_total++;
    idle(3);
  endtask : bus_write
  task bus_read(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= 1'b1;
    do begin @(posedge sys_clk); n++; end while (avs_waitrequest !== 1'b0 && n < 40);
    d = avs_readdata;
    avs_read <= 1'b0;
    if (n >= 40) err_total++;
    @(posedge sys_clk);
  endtask : bus_read
  // Port instruction on one line's latch
  task set_latch(input logic mel, input logic v);
    if (mel) begin mel_wr <= 1'b1; mel_wd <= v; end
    else begin clk_wr <= 1'b1; clk_wd <= v; end
    @(posedge sys_clk);
    mel_wr <= 1'b0;
    clk_wr <= 1'b0;
    idle(6);
  endtask : set_latch
  // Count high samples and level changes of one line over n cycles
  task measure(input logic mel, input int n);
    logic prev, cur;
    hs = 0;
    tg = 0;
    @(posedge sys_clk);
    prev = mel ? mel_out : clk_out;
    repeat (n) begin
      @(posedge sys_clk);
      cur = mel ? mel_out : clk_out;
      if (cur === 1'b1) hs++;
      if (cur !== prev) tg++;
      prev = cur;
    end
  endtask : measure
  task test_reset;
    bus_read(A_CTL, rd);
    check("control after reset", rd, 32'h0000_0000);
    check("tone oe after reset", tone_oe, 1'b0);
    check("power down after reset", tone_power_down, 1'b1);
    check("clock line oe", clk_oe, 1'b0);
    check("melody line oe", mel_oe, 1'b0);
  endtask : test_reset
  task test_registers;
    bus_write(A_CTL, 32'h0000_00FF, 4'hF);
    bus_read(A_CTL, rd);
    check("control upper bits", rd, 32'h0000_0007);
    bus_write(A_CTL, 32'h0000_0000, 4'h0);
    bus_read(A_CTL, rd);
    check("control lane off", rd, 32'h0000_0007);
    bus_write(A_CTL, 32'h0000_0000, 4'hF);
    bus_write(A_HGF, 32'h0000_0055, 4'hF);
    bus_read(A_HGF, rd);
    check("high freq write only", rd, 32'h0000_0000);
    bus_read(8'hFC, rd);
    check("unmapped read", rd, 32'h0000_0000);
    bus_write(A_HGF, 32'h0000_0000, 4'hF);
  endtask : test_registers
  task test_clock_line;
    set_latch(1'b0, 1'b0);
    check("clock latch low", clk_latch, 1'b0);
    check("clock line drives low", {clk_oe, clk_out}, 2'b10);
    check("clock pin state low", clk_pin, 1'b0);
    set_latch(1'b0, 1'b1);
    bus_write(A_CTL, 32'h0000_0004, 4'hF);
    check("clock out oe", clk_oe, 1'b1);
    measure(1'b0, 12);
    check("undivided highs", hs, 6);
    check("undivided toggles", tg, 12);
    bus_write(A_CTL, 32'h0000_0006, 4'hF);
    measure(1'b0, 12);
    check("divided highs", hs, 6);
    check("divided toggles", tg, 4);
    ce <= 1'b0;
    measure(1'b0, 6);
    check("clock frozen by enable", tg, 0);
    ce <= 1'b1;
    set_latch(1'b0, 1'b0);
    check("clock latch writable", clk_latch, 1'b0);
    set_latch(1'b0, 1'b1);
    check("clock latch readable", clk_latch, 1'b1);
    bus_write(A_CTL, 32'h0000_0000, 4'hF);
    check("clock line released", clk_oe, 1'b0);
  endtask : test_clock_line
  task test_melody;
    set_latch(1'b1, 1'b1);
    bus_write(A_CTL, 32'h0000_0001, 4'hF);
    idle(4);
    check("melody static high", {mel_oe, mel_out}, 2'b11);
    check("melody pin high", mel_pin, 1'b1);
    bus_write(A_HGF, 32'h0000_0002, 4'hF);
    check("tone oe on", tone_oe, 1'b1);
    check("power down off", tone_power_down, 1'b0);
    measure(1'b1, 368);
    check("melody highs", hs, 192);
    check("melody toggles", tg, 4);
    rd = {27'h0, hi_ph};
    idle(8);
    check("high phase step", hi_ph, (rd + 1) % 23);
    bus_read(A_STS, rd);
    check("status high run", rd & 32'h0000_001D, 32'h0000_000D);
    set_latch(1'b1, 1'b0);
    check("melody latch writable", mel_latch, 1'b0);
    set_latch(1'b1, 1'b1);
    check("melody latch readable", mel_latch, 1'b1);
    bus_write(A_HGF, 32'h0000_0000, 4'hF);
    check("high phase stopped", hi_ph, 5'h00);
    bus_write(A_LGF, 32'h0000_003C, 4'hF);
    check("low only tone oe", tone_oe, 1'b1);
    check("low only melody high", mel_out, 1'b1);
    bus_read(A_STS, rd);
    check("status low only", rd, 32'h0000_0017);
    bus_write(A_LGF, 32'h0000_0000, 4'hF);
    check("low phase stopped", lo_ph, 5'h00);
    check("both zero tone oe", tone_oe, 1'b0);
    check("both zero power down", tone_power_down, 1'b1);
    bus_write(A_CTL, 32'h0000_0000, 4'hF);
    check("melody line released", mel_oe, 1'b0);
  endtask : test_melody
  task print_verdict;
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    {clk_wr, clk_wd, mel_wr, mel_wd} = 4'h5;
    err_total = 0;
    n_tests = 0;
    cyc = 0;
    idle(6);
    resetn <= 1'b1;
    idle(2);
    test_reset();
    test_registers();
    test_clock_line();
    test_melody();
    print_verdict();
  end
endmodule : tb_tone_generator_clock_and_melody_control
